//--- toc_pkg.sv
/*
  Package for the trace option control block: register offsets, field
  layouts, capability encodings, reset values and the element carriers.
  Assumes one 10 MHz clock and core-side inputs synchronous to it.
*/
// Functional notes
// - enabled context tag outputs running process id
// - context width field gates context enable bit
// - enabled vm tag outputs running machine id
// - vm width field gates vm enable bit
// - count spans last two counted commits
// - count emitted and restarted at one only at threshold
// - cycle support gates threshold register, enable
// - sample system stamp, insert absolute value
// - stamp width is 48 or 64 bits
// - stamp after trace info and overflow recovery
// - stamp on exception, return, barrier, flush
// - event control adds unit-event stamp points
// - stamping needs support and enable bit
// - stamp width field gates event register, enable
// - cond branches always; non-branch modes selectable
// - explicit loads/stores selectable as four modes
// - data address, value, or both selectable
// - data tracing implies explicit load/store support
// - condensed element may replace explicit elements
// - broadcast traces direct branch, barrier targets
package toc_pkg;
  localparam logic [11:0] TOC_CONFIG_OFF   = 12'h010;
  localparam logic [11:0] TOC_THRESH_OFF   = 12'h028;
  localparam logic [11:0] TOC_STAMP_EV_OFF = 12'h030;
  localparam logic [11:0] TOC_CAP0_OFF     = 12'h1e0;
  localparam logic [11:0] TOC_CAP2_OFF     = 12'h1e8;
  localparam logic [31:0] TOC_CONFIG_RST   = 32'h0000_0000;
  localparam logic [11:0] TOC_THRESH_RST   = 12'h001;
  localparam logic [3:0]  TOC_STAMP_EV_RST = 4'h0;
  localparam logic [4:0]  TOC_STAMP48_CODE = 5'h06;
  localparam logic [4:0]  TOC_STAMP64_CODE = 5'h08;
  localparam logic [4:0]  TOC_CTX_W_CODE   = 5'h04;
  localparam logic [4:0]  TOC_VM_W_CODE    = 5'h02;
  localparam logic [63:0] TOC_STAMP48_MASK = 64'h0000_ffff_ffff_ffff;
  localparam logic [15:0] TOC_CC_ONE       = 16'h0001;
  localparam logic [15:0] TOC_CC_MAX       = 16'hffff;
  localparam logic [7:0]  TOC_Q_ONE        = 8'h01;
  localparam logic [7:0]  TOC_Q_MAX        = 8'hff;
  localparam logic [2:0]  TOC_COND_LOAD    = 3'h1;
  localparam logic [2:0]  TOC_COND_STORE   = 3'h2;
  localparam logic [2:0]  TOC_COND_BOTH    = 3'h3;
  localparam logic [2:0]  TOC_COND_ALL     = 3'h7;

  typedef enum logic [1:0] {
    TOC_Q_IDLE = 2'b01,
    TOC_Q_RUN  = 2'b10
  } toc_q_state_type;

  typedef struct packed {
    logic [13:0] rsv_hi;
    logic        data_value_en;
    logic        data_addr_en;
    logic [1:0]  condensed_en;
    logic [1:0]  rsv_mid;
    logic        stamp_enable;
    logic [2:0]  cond_mode;
    logic        virtual_machine_tag;
    logic        context_tag_enable;
    logic        rsv_5;
    logic        cycle_tally_enable;
    logic        branch_bcast_en;
    logic [1:0]  explicit_ldst;
    logic        rsv_0;
  } toc_config_type;

  typedef struct packed {
    logic [2:0]  rsv_hi;
    logic [4:0]  stamp_width;
    logic [13:0] rsv_mid;
    logic        condensed_supported;
    logic        rsv_8;
    logic        cycle_tally_supported;
    logic        cond_supported;
    logic        bcast_supported;
    logic        rsv_4;
    logic        data_supported;
    logic        rsv_2;
    logic        explicit_supported;
    logic        rsv_0;
  } toc_cap0_type;

  typedef struct packed {
    logic [21:0] rsv_hi;
    logic [4:0]  virtual_machine_tag_width;
    logic [4:0]  context_tag_width;
  } toc_cap2_type;

  typedef struct packed {
    logic        commit;
    logic        instr_retired;
    logic        is_load;
    logic        is_store;
    logic        cond_instr;
    logic        cond_branch;
    logic        direct_branch;
    logic        barrier_instruction;
    logic [31:0] branch_target;
    logic        exc_taken;
    logic        exc_return;
    logic        data_xfer;
    logic [31:0] data_addr;
    logic [31:0] data_value;
    logic [31:0] context_id;
    logic [15:0] vm_id;
  } toc_core_type;

  typedef struct packed {
    logic       trace_info_inst;
    logic       trace_info_data;
    logic       overflow_recovered;
    logic       flush_req;
    logic [3:0] unit_event;
  } toc_unit_type;

  typedef struct packed {
    logic        ctx_valid;
    logic [31:0] ctx_tag;
    logic        vm_valid;
    logic [15:0] vm_tag;
    logic        cc_valid;
    logic [15:0] cc_value;
    logic        ts_valid;
    logic [63:0] ts_value;
    logic        p0_valid;
    logic        p0_load;
    logic        p0_store;
    logic        cond_valid;
    logic        bb_valid;
    logic [31:0] bb_target;
    logic        da_valid;
    logic [31:0] da_addr;
    logic        dv_valid;
    logic [31:0] dv_value;
    logic        q_valid;
    logic [7:0]  q_count;
  } toc_trace_type;
endpackage

//--- toc_option_ctrl.sv
/*
  Trace option control: configuration registers, capability words and
  generation of context, vm, cycle count, timestamp, explicit, condition,
  broadcast, data and condensed elements from per-cycle core reports.
  Assumes a register master that never strobes read and write together
  and core/unit inputs synchronous to ref_clk.
*/
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
module toc_option_ctrl
  import toc_pkg::*;
#(
  parameter bit HAS_CTX       = 1'b1,
  parameter bit HAS_VM        = 1'b1,
  parameter bit HAS_CYCLE     = 1'b1,
  parameter bit HAS_STAMP     = 1'b1,
  parameter int STAMP_BITS    = 64,
  parameter bit HAS_BCAST     = 1'b1,
  parameter bit HAS_COND      = 1'b1,
  parameter bit HAS_EXPLICIT  = 1'b1,
  parameter bit HAS_DATA      = 1'b1,
  parameter bit HAS_CONDENSED = 1'b1
)(
  input  logic          ref_clk,
  input  logic          reset_n,
  input  logic [11:0]   reg_addr,
  input  logic [31:0]   reg_wdata,
  input  logic          reg_write,
  input  logic          reg_read,
  output logic [31:0]   reg_rdata,
  input  toc_core_type  core_in,
  input  toc_unit_type  unit_in,
  input  logic [63:0]   sys_stamp,
  output toc_trace_type trace_out
);

  // data tracing drags in explicit load/store and stamping
  localparam bit EXPL_ON  = HAS_EXPLICIT | HAS_DATA;
  localparam bit STAMP_ON = HAS_STAMP | HAS_DATA;
  // any width other than 48 falls back to 64
  localparam bit STAMP_48 = (STAMP_BITS == 48);

  typedef struct packed {
    toc_config_type  cfg;
    logic [11:0]     thresh;
    logic [3:0]      stamp_ev;
    logic [31:0]     rdata;
    logic [15:0]     cc_count;
    logic            ctx_armed;
    logic [31:0]     ctx_last;
    logic            vm_armed;
    logic [15:0]     vm_last;
    toc_q_state_type q_state;
    logic [7:0]      q_count;
    toc_trace_type   out;
  } toc_state_type;

  toc_state_type  state_reg;
  toc_state_type  state_next;
  toc_config_type cfg_mask;
  toc_cap0_type   cap0;
  toc_cap2_type   cap2;
  logic [63:0]    stamp_mask;
  logic           stamp_hit;
  logic           cond_hit;
  logic           ld_sel;
  logic           st_sel;
  logic           q_allowed;

  assign reg_rdata = state_reg.rdata;
  assign trace_out = state_reg.out;
  assign stamp_mask = STAMP_48 ? TOC_STAMP48_MASK : '1;

  // writable enable bits exist only for implemented features
  always_comb begin
    cfg_mask = '0;
    cfg_mask.context_tag_enable  = HAS_CTX;
    cfg_mask.virtual_machine_tag = HAS_VM;
    cfg_mask.cycle_tally_enable  = HAS_CYCLE;
    cfg_mask.stamp_enable        = STAMP_ON;
    cfg_mask.branch_bcast_en     = HAS_BCAST;
    cfg_mask.cond_mode           = {3{HAS_COND}};
    cfg_mask.explicit_ldst       = {2{EXPL_ON}};
    cfg_mask.data_addr_en        = HAS_DATA;
    cfg_mask.data_value_en       = HAS_DATA;
    cfg_mask.condensed_en        = {2{HAS_CONDENSED}};
  end

  always_comb begin
    cap0 = '0;
    cap2 = '0;
    cap0.explicit_supported    = EXPL_ON;
    cap0.data_supported        = HAS_DATA;
    cap0.bcast_supported       = HAS_BCAST;
    cap0.cond_supported        = HAS_COND;
    cap0.cycle_tally_supported = HAS_CYCLE;
    cap0.condensed_supported   = HAS_CONDENSED;
    if (STAMP_ON) begin
      cap0.stamp_width = STAMP_48 ? TOC_STAMP48_CODE : TOC_STAMP64_CODE;
    end
    if (HAS_CTX) begin
      cap2.context_tag_width = TOC_CTX_W_CODE;
    end
    if (HAS_VM) begin
      cap2.virtual_machine_tag_width = TOC_VM_W_CODE;
    end
  end

  // stamp insertion points, fixed plus event-selected
  always_comb begin
    stamp_hit = unit_in.trace_info_inst;
    if (unit_in.trace_info_data &&
        (state_reg.cfg.data_addr_en || state_reg.cfg.data_value_en)) begin
      stamp_hit = 1'b1;
    end
    if (unit_in.overflow_recovered || unit_in.flush_req) begin
      stamp_hit = 1'b1;
    end
    if (core_in.exc_taken || core_in.exc_return ||
        core_in.barrier_instruction) begin
      stamp_hit = 1'b1;
    end
    if ((unit_in.unit_event & state_reg.stamp_ev) != 4'h0) begin
      stamp_hit = 1'b1;
    end
  end

  // condition mode decode for non-branch instructions
  always_comb begin
    case (state_reg.cfg.cond_mode)
      TOC_COND_LOAD:  cond_hit = core_in.is_load;
      TOC_COND_STORE: cond_hit = core_in.is_store;
      TOC_COND_BOTH:  cond_hit = core_in.is_load | core_in.is_store;
      TOC_COND_ALL:   cond_hit = 1'b1;
      default:        cond_hit = 1'b0;
    endcase
  end

  assign ld_sel = core_in.is_load & state_reg.cfg.explicit_ldst[0];
  assign st_sel = core_in.is_store & state_reg.cfg.explicit_ldst[1];
  // condensing would hide the instructions data and condition trace key on
  assign q_allowed = (state_reg.cfg.condensed_en != 2'b00) &&
                     !state_reg.cfg.data_addr_en &&
                     !state_reg.cfg.data_value_en &&
                     (state_reg.cfg.cond_mode == 3'h0);

  always_comb begin
    state_next = state_reg;
    state_next.out = '0;
    state_next.rdata = '0;

    if (reg_write) begin
      case (reg_addr)
        TOC_CONFIG_OFF: begin
          state_next.cfg = toc_config_type'(reg_wdata & cfg_mask);
        end
        TOC_THRESH_OFF: begin
          if (HAS_CYCLE) begin
            state_next.thresh = reg_wdata[11:0];
          end
        end
        TOC_STAMP_EV_OFF: begin
          if (STAMP_ON) begin
            state_next.stamp_ev = reg_wdata[3:0];
          end
        end
        default: begin
        end
      endcase
    end

    if (reg_read) begin
      case (reg_addr)
        TOC_CONFIG_OFF:   state_next.rdata = state_reg.cfg;
        TOC_THRESH_OFF:   state_next.rdata = {20'h00000, state_reg.thresh};
        TOC_STAMP_EV_OFF: state_next.rdata = {28'h0000000, state_reg.stamp_ev};
        TOC_CAP0_OFF:     state_next.rdata = cap0;
        TOC_CAP2_OFF:     state_next.rdata = cap2;
        default:          state_next.rdata = '0;
      endcase
    end

    // context tag: on enable, on change and with each instruction trace info
    if (!state_reg.cfg.context_tag_enable) begin
      state_next.ctx_armed = 1'b0;
    end else if (!state_reg.ctx_armed || unit_in.trace_info_inst ||
                 (core_in.context_id != state_reg.ctx_last)) begin
      state_next.out.ctx_valid = 1'b1;
      state_next.out.ctx_tag = core_in.context_id;
      state_next.ctx_last = core_in.context_id;
      state_next.ctx_armed = 1'b1;
    end

    if (!state_reg.cfg.virtual_machine_tag) begin
      state_next.vm_armed = 1'b0;
    end else if (!state_reg.vm_armed || unit_in.trace_info_inst ||
                 (core_in.vm_id != state_reg.vm_last)) begin
      state_next.out.vm_valid = 1'b1;
      state_next.out.vm_tag = core_in.vm_id;
      state_next.vm_last = core_in.vm_id;
      state_next.vm_armed = 1'b1;
    end

    // counter restarts at one so the next value spans commit to commit
    if (!state_reg.cfg.cycle_tally_enable) begin
      state_next.cc_count = '0;
    end else if (core_in.commit &&
                 (state_reg.cc_count >= {4'h0, state_reg.thresh})) begin
      state_next.out.cc_valid = 1'b1;
      state_next.out.cc_value = state_reg.cc_count;
      state_next.cc_count = TOC_CC_ONE;
    end else if (state_reg.cc_count != TOC_CC_MAX) begin
      state_next.cc_count = state_reg.cc_count + TOC_CC_ONE;
    end

    if (state_reg.cfg.stamp_enable && stamp_hit) begin
      state_next.out.ts_valid = 1'b1;
      state_next.out.ts_value = sys_stamp & stamp_mask;
    end

    if (core_in.cond_branch ||
        (core_in.cond_instr && !core_in.direct_branch && cond_hit)) begin
      state_next.out.cond_valid = 1'b1;
    end

    if (state_reg.cfg.branch_bcast_en &&
        (core_in.direct_branch || core_in.barrier_instruction)) begin
      state_next.out.bb_valid = 1'b1;
      state_next.out.bb_target = core_in.branch_target;
    end

    // data only for transfers of explicitly traced instructions
    if (core_in.data_xfer && (ld_sel || st_sel)) begin
      if (state_reg.cfg.data_addr_en) begin
        state_next.out.da_valid = 1'b1;
        state_next.out.da_addr = core_in.data_addr;
      end
      if (state_reg.cfg.data_value_en) begin
        state_next.out.dv_valid = 1'b1;
        state_next.out.dv_value = core_in.data_value;
      end
    end

    case (state_reg.q_state)
      TOC_Q_IDLE: begin
        if (core_in.instr_retired && (ld_sel || st_sel)) begin
          if (q_allowed) begin
            state_next.q_state = TOC_Q_RUN;
            state_next.q_count = TOC_Q_ONE;
          end else begin
            state_next.out.p0_valid = 1'b1;
            state_next.out.p0_load = ld_sel;
            state_next.out.p0_store = st_sel;
          end
        end
      end
      TOC_Q_RUN: begin
        if (core_in.instr_retired && (ld_sel || st_sel) &&
            (state_reg.q_count != TOC_Q_MAX)) begin
          state_next.q_count = state_reg.q_count + TOC_Q_ONE;
        end
        // close the group at commit, or flush it if condensing stops
        if (core_in.commit || !q_allowed) begin
          state_next.out.q_valid = 1'b1;
          state_next.out.q_count = state_next.q_count;
          state_next.q_count = '0;
          state_next.q_state = TOC_Q_IDLE;
        end
      end
      default: begin
        state_next.q_state = TOC_Q_IDLE;
        state_next.q_count = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.cfg <= TOC_CONFIG_RST;
      state_reg.thresh <= TOC_THRESH_RST;
      state_reg.stamp_ev <= TOC_STAMP_EV_RST;
      state_reg.q_state <= TOC_Q_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  ctx_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    trace_out.ctx_valid |-> $past(state_reg.cfg.context_tag_enable) &&
      (trace_out.ctx_tag == $past(core_in.context_id)))
    else $error("context tag emitted while disabled or wrong value");

  vm_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    trace_out.vm_valid |-> $past(state_reg.cfg.virtual_machine_tag) &&
      (trace_out.vm_tag == $past(core_in.vm_id)))
    else $error("vm tag emitted while disabled or wrong value");

  absent_bits_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_reg.cfg & ~cfg_mask) == 32'h0000_0000)
    else $error("enable bit of absent feature became set");

  cycle_emit_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    trace_out.cc_valid == $past(core_in.commit &&
      state_reg.cfg.cycle_tally_enable &&
      (state_reg.cc_count >= {4'h0, state_reg.thresh})))
    else $error("cycle count element not tied to threshold at commit");

  cycle_restart_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    trace_out.cc_valid |-> (state_reg.cc_count == TOC_CC_ONE) &&
      (trace_out.cc_value == $past(state_reg.cc_count)))
    else $error("cycle counter not restarted after count element");

  stamp_value_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    trace_out.ts_valid |-> trace_out.ts_value == ($past(sys_stamp) & stamp_mask))
    else $error("timestamp element does not carry sampled stamp");

  stamp_barrier_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_reg.cfg.stamp_enable && core_in.barrier_instruction) |=> trace_out.ts_valid)
    else $error("barrier did not insert timestamp");

  stamp_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !state_reg.cfg.stamp_enable |=> !trace_out.ts_valid)
    else $error("timestamp emitted while stamping disabled");

  bcast_target_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_reg.cfg.branch_bcast_en && core_in.direct_branch) |=>
      trace_out.bb_valid && (trace_out.bb_target == $past(core_in.branch_target)))
    else $error("direct branch target not broadcast");

  cond_branch_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    core_in.cond_branch |=> trace_out.cond_valid)
    else $error("conditional branch not traced");

  cap_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (reg_read && (reg_addr == TOC_CAP0_OFF)) |=> reg_rdata == $past(cap0))
    else $error("capability word zero read back wrong");

  data_link_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (trace_out.da_valid || trace_out.dv_valid) |->
      $past(state_reg.cfg.explicit_ldst) != 2'b00)
    else $error("data element without explicit load/store tracing");

  stamp_info_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_reg.cfg.stamp_enable &&
      (unit_in.trace_info_inst || unit_in.overflow_recovered || unit_in.flush_req)) |=>
      trace_out.ts_valid)
    else $error("trace info, overflow or flush did not insert timestamp");

  stamp_exc_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_reg.cfg.stamp_enable && (core_in.exc_taken || core_in.exc_return)) |=>
      trace_out.ts_valid)
    else $error("exception entry or return did not insert timestamp");

  stamp_event_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_reg.cfg.stamp_enable && ((unit_in.unit_event & state_reg.stamp_ev) != 4'h0)) |=>
      trace_out.ts_valid)
    else $error("selected unit event did not insert timestamp");

  stamp_width_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (trace_out.ts_value & ~stamp_mask) == 64'h0)
    else $error("timestamp wider than implemented width");

  explicit_elem_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    trace_out.p0_valid |-> $past(core_in.instr_retired) &&
      (trace_out.p0_load == $past(ld_sel)) && (trace_out.p0_store == $past(st_sel)))
    else $error("explicit element does not match retired load or store");

  condensed_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    trace_out.q_valid |-> ($past(state_reg.q_state) == TOC_Q_RUN) &&
      (trace_out.q_count != 8'h00))
    else $error("condensed element outside a running group");

endmodule

//--- toc_core_model.sv
/*
  Behavioural traced core: turns the bench's request word into one cycle
  of core report on the element side of the option control block.
  Assumes req and addr_req change just after a rising ref_clk edge.
*/
`timescale 1ns/100ps
module toc_core_model
  import toc_pkg::*;
#(
  parameter logic [31:0] CTX_ID = 32'h0000_1234,
  parameter logic [15:0] VM_ID  = 16'h0042
)(
  input  wire logic [11:0] req,
  input  wire logic [31:0] addr_req,
  output toc_core_type     core_out
);
  always_comb begin
    core_out.commit              = req[0];
    core_out.instr_retired       = req[1];
    core_out.is_load             = req[2];
    core_out.is_store            = req[3];
    core_out.cond_instr          = req[4];
    core_out.cond_branch         = req[5];
    core_out.direct_branch       = req[6];
    core_out.barrier_instruction = req[7];
    core_out.exc_taken           = req[8];
    core_out.exc_return          = req[9];
    core_out.data_xfer           = req[10];
    // idle lines carry a pattern so a stale value can never match
    core_out.branch_target       = (req[6] | req[7]) ? addr_req : ~addr_req;
    core_out.data_addr           = req[10] ? addr_req : ~addr_req;
    core_out.data_value          = req[10] ? {addr_req[15:0], addr_req[31:16]} : addr_req;
    core_out.context_id          = CTX_ID;
    core_out.vm_id               = VM_ID;
  end
endmodule

//--- test_trace_optional_feature_control.sv
/*
  Bench for the trace option control: register reads and writes, element
  pulses through a core model, one instance with tags, cycle count and data absent.
  Assumes the design answers reads one cycle later and elements likewise.
*/
`timescale 1ns/100ps
module test_trace_optional_feature_control
  import toc_pkg::*;
;
  localparam logic [31:0] CTX_ID = 32'h0000_1234;
  localparam logic [15:0] VM_ID  = 16'h0042;
  localparam logic [11:0] P_COMMIT = 12'h001, P_RET = 12'h002, P_LD = 12'h004, P_ST = 12'h008;
  localparam logic [11:0] P_CI = 12'h010, P_CB = 12'h020, P_DB = 12'h040, P_BAR = 12'h080;
  localparam logic [11:0] P_EXC = 12'h100, P_ERET = 12'h200, P_DX = 12'h400;
  logic          ref_clk   = 1'b0;
  logic          reset_n   = 1'b0;
  logic [11:0]   reg_addr  = '0;
  logic [31:0]   reg_wdata = '0;
  logic          reg_write = 1'b0;
  logic          reg_read  = 1'b0;
  logic [31:0]   reg_rdata, rdata_off;
  logic [11:0]   req       = '0;
  logic [31:0]   addr_req  = 32'h0000_4a20;
  toc_core_type  core_in;
  toc_unit_type  unit_in   = '0;
  logic [63:0]   sys_stamp = 64'h00ff_0000_0000_0100;
  toc_trace_type trace_out;
  toc_trace_type trace_off;
  int            fails     = 0;
  int            checks    = 0;
  logic [11:0]   ts_req [9] = '{12'h0, 12'h0, 12'h0, 12'h0, P_EXC, P_ERET, P_BAR, 12'h0, 12'h0};
  logic [7:0]    ts_unit [9] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0, 8'h0, 8'h0, 8'h01, 8'h02};
  logic [2:0]    cm [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  logic [1:0]    ldst;

  always #50 ref_clk = ~ref_clk;
  // one free-running source feeds both instances alike
  always @(posedge ref_clk) sys_stamp <= sys_stamp + 64'h1;

  // model defaults carry the ids that CTX_ID and VM_ID expect
  toc_core_model core_u (
    .req(req), .addr_req(addr_req), .core_out(core_in));
  toc_option_ctrl dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .core_in(core_in),
    .unit_in(unit_in), .sys_stamp(sys_stamp), .trace_out(trace_out));
  // partial build: tags, cycle and data absent, 48-bit stamps
  toc_option_ctrl #(.HAS_CTX(1'b0), .HAS_VM(1'b0), .HAS_CYCLE(1'b0), .HAS_DATA(1'b0),
    .STAMP_BITS(48)) dut_off_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata_off), .core_in(core_in),
    .unit_in(unit_in), .sys_stamp(sys_stamp), .trace_out(trace_off));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  // leaves time just past the answer edge, where the read data stand
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
  endtask

  task automatic pulse(input logic [11:0] r, input logic [7:0] u);
    @(posedge ref_clk);
    req <= r;
    unit_in <= u;
    @(posedge ref_clk);
    req <= '0;
    unit_in <= '0;
    #1;
  endtask

  task automatic end_of_test();
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(TOC_CAP0_OFF);
    check(reg_rdata, 32'h0000_02ea | {3'h0, TOC_STAMP64_CODE, 24'h0});
    check(rdata_off, 32'h0000_0262 | {3'h0, TOC_STAMP48_CODE, 24'h0});
    @(posedge ref_clk);
    #1 check(reg_rdata, 32'h0);
    rd(TOC_CAP2_OFF);
    check(reg_rdata, {22'h0, TOC_VM_W_CODE, TOC_CTX_W_CODE});
    check(rdata_off, 32'h0);
    rd(TOC_THRESH_OFF);
    check(reg_rdata, {20'h0, TOC_THRESH_RST});
    wr(TOC_CAP0_OFF, 32'hffff_ffff);
    wr(TOC_CONFIG_OFF, 32'hffff_ffff);
    wr(12'h3fc, 32'hffff_ffff);
    rd(TOC_CAP0_OFF);
    check(reg_rdata, 32'h0000_02ea | {3'h0, TOC_STAMP64_CODE, 24'h0});
    rd(TOC_CONFIG_OFF);
    check(reg_rdata, 32'h0003_cfde);
    check(rdata_off, 32'h0000_cf0e);
    rd(12'h3fc);
    check(reg_rdata, 32'h0);
    wr(TOC_THRESH_OFF, 32'h0000_0004);
    wr(TOC_STAMP_EV_OFF, 32'h0000_0005);
    rd(TOC_STAMP_EV_OFF);
    check(reg_rdata, 32'h5);
    pulse(12'h0, 8'h80);
    check(trace_out.ctx_valid, 1'b1);
    check(trace_out.ctx_tag, CTX_ID);
    check(trace_out.vm_valid, 1'b1);
    check(trace_out.vm_tag, VM_ID);
    check({trace_off.ctx_valid, trace_off.vm_valid}, 2'b00);
    for (int i = 0; i < 9; i++) begin
      pulse(ts_req[i], ts_unit[i]);
      check(trace_out.ts_valid, i < 8);
      check(trace_out.ts_value, (i < 8) ? sys_stamp - 64'h1 : 64'h0);
      // no data stream in the partial build, so trace info data adds no stamp there
      check(trace_off.ts_valid, i < 8 && i != 1);
      check(trace_off.ts_value,
            (i < 8 && i != 1) ? (sys_stamp - 64'h1) & TOC_STAMP48_MASK : 64'h0);
    end
    // the first commit finds a count long past threshold; gaps then are 2 and 4
    pulse(P_COMMIT, 8'h0);
    check(trace_out.cc_valid, 1'b1);
    check(trace_off.cc_valid, 1'b0);
    pulse(P_COMMIT, 8'h0);
    check(trace_out.cc_valid, 1'b0);
    pulse(P_COMMIT, 8'h0);
    check(trace_out.cc_value, 64'h4);
    pulse(P_DB, 8'h0);
    check(trace_out.bb_target, addr_req);
    pulse(P_BAR, 8'h0);
    check(trace_out.bb_valid, 1'b1);
    pulse(P_RET | P_LD | P_DX, 8'h0);
    check(trace_out.da_addr, addr_req);
    check(trace_out.dv_value, {addr_req[15:0], addr_req[31:16]});
    wr(TOC_CONFIG_OFF, 32'h0001_0002);
    pulse(P_RET | P_ST | P_DX, 8'h0);
    check(trace_out.da_valid, 1'b0);
    pulse(P_RET | P_LD | P_DX, 8'h0);
    check({trace_out.da_valid, trace_out.dv_valid}, 2'b10);
    for (int i = 0; i < 5; i++) begin
      ldst = i[1:0];
      wr(TOC_CONFIG_OFF, {21'h0, cm[i], 5'h0, ldst, 1'b0});
      pulse(P_RET | P_CI | P_LD, 8'h0);
      check({trace_out.cond_valid, trace_out.p0_valid}, {cm[i] inside {1, 3, 7}, ldst[0]});
      pulse(P_RET | P_CI | P_ST, 8'h0);
      check({trace_out.cond_valid, trace_out.p0_valid}, {cm[i] inside {2, 3, 7}, ldst[1]});
      pulse(P_CI, 8'h0);
      check(trace_out.cond_valid, cm[i] == 3'h7);
      pulse(P_CB, 8'h0);
      check(trace_out.cond_valid, 1'b1);
    end
    pulse(P_BAR, 8'h0);
    check({trace_out.ts_valid, trace_out.bb_valid}, 2'b00);
    wr(TOC_CONFIG_OFF, 32'h0000_4006);
    pulse(P_RET | P_LD, 8'h0);
    check(trace_out.p0_valid, 1'b0);
    pulse(P_RET | P_ST, 8'h0);
    pulse(P_COMMIT, 8'h0);
    check({trace_out.q_valid, trace_out.q_count}, {1'b1, 8'h02});
    end_of_test();
  end
endmodule
